// ==== logic/stpm_pkg.sv ====
// Shared constants and types for the serial transceiver power manager
package stpm_pkg;
    // Clock rate, kept in MHz so products stay small
    localparam int unsigned CLK_MHZ = 125;

    // Times as specified, in their own units
    localparam int unsigned INACT_TIME_S = 30;
    localparam int unsigned INVALID_TIME_US = 30;
    localparam int unsigned VALID_TIME_US = 1;
    localparam int unsigned WAKE_TIME_US = 100;

    // Cycle counts derived from the times; the 30 s one needs 64-bit math
    localparam logic [31:0] INACT_CYC = 32'(64'(INACT_TIME_S) * 64'(CLK_MHZ) * 64'd1000000);
    localparam logic [12:0] INVALID_CYC = 13'(INVALID_TIME_US * CLK_MHZ);
    localparam logic [12:0] VALID_CYC = 13'(VALID_TIME_US * CLK_MHZ);
    localparam logic [31:0] WAKE_CYC = 32'(WAKE_TIME_US * CLK_MHZ);

    // Default channel counts
    localparam int unsigned NUM_TX = 3;
    localparam int unsigned NUM_RX = 5;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;

    // Control register layout and reset value
    localparam int unsigned CTRL_FIVE_RX_BIT = 0;
    localparam int unsigned CTRL_SOFT_WAKE_BIT = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

    // AXI response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Power state of the transmit path
    typedef enum logic [1:0] {
        ST_OFF,
        ST_WAKE,
        ST_ON
    } stpm_state_type;

    // Filtered control pins
    typedef struct packed {
        logic shut_n;
        logic dis;
    } stpm_ctl_type;

    // Status word as seen by software, high bits first
    typedef struct packed {
        logic [24:0] zero;
        logic dis;
        logic shut_n;
        logic expired;
        logic armed;
        logic valid;
        logic ready;
        logic want_on;
    } stpm_stat_type;
endpackage : stpm_pkg

// ==== logic/stpm_power_manager.sv ====
// Power manager: inactivity timer, line validity detector, wake sequencing, AXI4-Lite registers
// Functional notes
// - Shutdown input low forces powerdown, whatever the disable input says.
// - Shutdown and disable both high keep the device permanently active.
// - Auto powerdown is armed only with disable low and shutdown high.
// - Armed and 30 s without any input edge switches pump and transmitters off.
// - Any edge on a monitored transmitter or receiver input powers back up.
// - After auto powerdown the timer stays expired until disable rises or an edge.
// - From manual powerdown with disable low, wake needs both inputs high or an edge.
// - Falling edge on disable restarts the timer for a full 30 s.
// - Wake from powerdown to transmit-ready takes nominally 100 us.
// - Validity output falls once all receivers are invalid for over 30 us.
// - Validity output rises 1 us after any receiver sees a valid level.
// - Validity works in every mode and never changes the power state itself.
// - Five-receiver variant disables inverting receiver outputs while powered down.
// - Validity on shutdown, disable low: stays off until valid and an edge.
// - In powerdown transmitters are high impedance; other receiver outputs stay on.
// - Ready falls on powerdown entry and rises only when power-up completes.
module stpm_power_manager #(
    parameter int unsigned NTX = stpm_pkg::NUM_TX,
    parameter int unsigned NRX = stpm_pkg::NUM_RX,
    parameter logic [31:0] INACT_CYC = stpm_pkg::INACT_CYC,
    parameter logic [31:0] WAKE_CYC = stpm_pkg::WAKE_CYC
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [NTX-1:0] tx_in,
    input wire logic [NRX-1:0] rx_in,
    input wire logic [NRX-1:0] rx_level_ok,
    input wire logic manual_shutdown_n,
    input wire logic auto_pd_disable_in,
    output logic pump_en,
    output logic tx_oe,
    output logic rx_inv_oe,
    output logic rx_wake_oe,
    output logic ready_out,
    output logic valid_out,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    localparam int unsigned PW = NTX + 2 * NRX + 2;
    localparam int unsigned DW = NTX + NRX;

    // Pin synchroniser, three stages, filtered value follows when stages 2 and 3 agree
    logic [PW-1:0] pins_raw, agree, filt_nxt;
    logic [PW-1:0] sync1_r, sync2_r, sync3_r, filt_r;

    assign pins_raw = {rx_level_ok, manual_shutdown_n, auto_pd_disable_in, rx_in, tx_in};
    assign agree = ~(sync2_r ^ sync3_r);
    assign filt_nxt = (sync3_r & agree) | (filt_r & ~agree);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            filt_r <= '0;
        end else begin
            sync1_r <= pins_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            filt_r <= filt_nxt;
        end
    end

    // Decoded filtered inputs and their edges
    stpm_pkg::stpm_ctl_type ctl;
    wire [NRX-1:0] lvl_f = filt_r[PW-1 -: NRX];
    wire [DW-1:0] data_chg = filt_nxt[DW-1:0] ^ filt_r[DW-1:0];
    wire data_edge = |data_chg;
    wire dis_fall = filt_r[DW] & ~filt_nxt[DW];
    wire lvl_any = |lvl_f;

    assign ctl.shut_n = filt_r[DW+1];
    assign ctl.dis = filt_r[DW];

    // Software registers, written below by the bus slave
    logic [31:0] ctrl_r;
    logic soft_wake_r;
    wire five_rx = ctrl_r[stpm_pkg::CTRL_FIVE_RX_BIT];

    // Inactivity timer; disable held high restarts it every cycle while shutdown is high
    logic [31:0] inact_cnt_r, inact_cnt_nxt;
    logic expired_r, expired_nxt;
    wire armed = ctl.shut_n & ~ctl.dis;
    wire activity = data_edge | soft_wake_r;
    wire restart = activity | dis_fall | ctl.dis;
    wire time_up = (inact_cnt_r == INACT_CYC - 32'h1);

    assign inact_cnt_nxt = (ctl.shut_n && restart) ? 32'h0 :
                           (!ctl.shut_n || expired_r) ? inact_cnt_r :
                           inact_cnt_r + 32'h1;
    // Shutdown pins the timer expired; an edge only counts once shutdown is released
    assign expired_nxt = !ctl.shut_n ? 1'b1 :
                         restart ? 1'b0 :
                         (armed && time_up) ? 1'b1 :
                         expired_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inact_cnt_r <= 32'h0;
            expired_r <= 1'b0;
        end else begin
            inact_cnt_r <= inact_cnt_nxt;
            expired_r <= expired_nxt;
        end
    end

    // Power wanted: shutdown overrides, disable keeps on, else timer decides
    wire want_on = ctl.shut_n & (ctl.dis | ~expired_r);

    // Wake sequencing: pump first, transmitters and ready after the latency
    stpm_pkg::stpm_state_type state_r, state_nxt;
    logic [31:0] wake_cnt_r, wake_cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        wake_cnt_nxt = 32'h0;
        case (state_r)
            stpm_pkg::ST_OFF: begin
                if (want_on) begin
                    state_nxt = stpm_pkg::ST_WAKE;
                end
            end
            stpm_pkg::ST_WAKE: begin
                if (!want_on) begin
                    state_nxt = stpm_pkg::ST_OFF;
                end else if (wake_cnt_r == WAKE_CYC - 32'h1) begin
                    state_nxt = stpm_pkg::ST_ON;
                end else begin
                    wake_cnt_nxt = wake_cnt_r + 32'h1;
                end
            end
            default: begin
                if (!want_on) begin
                    state_nxt = stpm_pkg::ST_OFF;
                end
            end
        endcase
    end

    // Output stage registered from next state so outputs track it exactly
    logic pump_en_r, tx_oe_r, rx_inv_oe_r, rx_wake_oe_r, ready_r, valid_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_r <= stpm_pkg::ST_OFF;
            wake_cnt_r <= 32'h0;
            pump_en_r <= 1'b0;
            tx_oe_r <= 1'b0;
            rx_inv_oe_r <= 1'b0;
            rx_wake_oe_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            wake_cnt_r <= wake_cnt_nxt;
            pump_en_r <= (state_nxt != stpm_pkg::ST_OFF);
            tx_oe_r <= (state_nxt == stpm_pkg::ST_ON);
            rx_inv_oe_r <= !five_rx || (state_nxt != stpm_pkg::ST_OFF);
            rx_wake_oe_r <= 1'b1;
            ready_r <= (state_nxt == stpm_pkg::ST_ON);
        end
    end

    // Validity detector, independent of power state so it runs in every mode
    logic [12:0] inv_cnt_r, val_cnt_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            inv_cnt_r <= 13'h0;
            val_cnt_r <= 13'h0;
            valid_r <= 1'b0;
        end else if (lvl_any) begin
            inv_cnt_r <= 13'h0;
            if (val_cnt_r == stpm_pkg::VALID_CYC - 13'h1) begin
                valid_r <= 1'b1;
            end else if (!valid_r) begin
                val_cnt_r <= val_cnt_r + 13'h1;
            end
        end else begin
            val_cnt_r <= 13'h0;
            // Strictly more than the window: one extra cycle past the count
            if (inv_cnt_r == stpm_pkg::INVALID_CYC) begin
                valid_r <= 1'b0;
            end else begin
                inv_cnt_r <= inv_cnt_r + 13'h1;
            end
        end
    end

    assign pump_en = pump_en_r;
    assign tx_oe = tx_oe_r;
    assign rx_inv_oe = rx_inv_oe_r;
    assign rx_wake_oe = rx_wake_oe_r;
    assign ready_out = ready_r;
    assign valid_out = valid_r;

    // AXI4-Lite slave; ready pulses one cycle after valid, simple and glitch free
    logic awready_r, wready_r, aw_have_r, w_have_r, bvalid_r, arready_r, rvalid_r, rd_known;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [3:0] wstrb_r;
    logic [1:0] bresp_r, rresp_r;

    wire aw_hs = s_axi_awvalid & awready_r;
    wire w_hs = s_axi_wvalid & wready_r;
    wire ar_hs = s_axi_arvalid & arready_r;
    wire do_write = aw_have_r & w_have_r & ~bvalid_r;
    wire wr_ctrl = do_write && (awaddr_r == stpm_pkg::CTRL_OFFS);
    wire wr_known = wr_ctrl || (awaddr_r == stpm_pkg::STATUS_OFFS);

    // Read mux, unmapped addresses read zero with an error response
    stpm_pkg::stpm_stat_type stat;
    logic [31:0] rd_word;

    assign stat = '{zero: '0, dis: ctl.dis, shut_n: ctl.shut_n, expired: expired_r,
                    armed: armed, valid: valid_r, ready: ready_r, want_on: want_on};

    always_comb begin
        rd_word = 32'h0;
        rd_known = 1'b1;
        if (s_axi_araddr == stpm_pkg::CTRL_OFFS) begin
            rd_word = ctrl_r;
        end else if (s_axi_araddr == stpm_pkg::STATUS_OFFS) begin
            rd_word = stat;
        end else begin
            rd_known = 1'b0;
        end
    end

    // Write address and data channels, taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
        end else begin
            awready_r <= s_axi_awvalid & ~awready_r & ~aw_have_r & ~bvalid_r;
            wready_r <= s_axi_wvalid & ~wready_r & ~w_have_r & ~bvalid_r;
            if (aw_hs) begin
                aw_have_r <= 1'b1;
                awaddr_r <= {s_axi_awaddr[7:2], 2'b00};
            end else if (do_write) begin
                aw_have_r <= 1'b0;
            end
            if (w_hs) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end else if (do_write) begin
                w_have_r <= 1'b0;
            end
        end
    end

    // Write response and register update; soft wake is a one-cycle activity pulse
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= stpm_pkg::RESP_OKAY;
            ctrl_r <= stpm_pkg::CTRL_RESET;
            soft_wake_r <= 1'b0;
        end else begin
            soft_wake_r <= wr_ctrl && wstrb_r[0] && wdata_r[stpm_pkg::CTRL_SOFT_WAKE_BIT];
            if (wr_ctrl && wstrb_r[0]) begin
                ctrl_r <= {31'h0, wdata_r[stpm_pkg::CTRL_FIVE_RX_BIT]};
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= wr_known ? stpm_pkg::RESP_OKAY : stpm_pkg::RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0;
            rresp_r <= stpm_pkg::RESP_OKAY;
        end else begin
            arready_r <= s_axi_arvalid & ~arready_r & ~rvalid_r;
            if (ar_hs) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_word;
                rresp_r <= rd_known ? stpm_pkg::RESP_OKAY : stpm_pkg::RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // Checks on the power and validity behaviour
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence wake_done_s;
        state_r == stpm_pkg::ST_WAKE && wake_cnt_r == WAKE_CYC - 32'h1 && want_on;
    endsequence

    sequence still_invalid_s;
        !lvl_any && inv_cnt_r == stpm_pkg::INVALID_CYC;
    endsequence

    shutdown_off_a: assert property (!ctl.shut_n |=> !tx_oe_r && !ready_r && !pump_en_r)
        else $error("shutdown did not turn the transmit path off");
    forced_on_a: assert property (ctl.shut_n && ctl.dis |=> !expired_r)
        else $error("timer expired while disabled and not shut down");
    timeout_off_a: assert property (armed && time_up && !restart |=> expired_r ##1 !pump_en_r)
        else $error("inactivity timeout did not power down");
    edge_wake_a: assert property (ctl.shut_n && activity |=> !expired_r ##1 pump_en_r)
        else $error("input edge did not wake the device");
    manual_hold_a: assert property (!ctl.shut_n |=> expired_r)
        else $error("timer not held expired in shutdown");
    dis_restart_a: assert property (dis_fall && ctl.shut_n |=> inact_cnt_r == 32'h0 && !expired_r)
        else $error("disable falling edge did not restart the timer");
    wake_ready_a: assert property (wake_done_s |=> ready_r && tx_oe_r)
        else $error("ready not raised after wake latency");
    ready_low_a: assert property (state_r == stpm_pkg::ST_WAKE |-> !ready_r)
        else $error("ready high before wake completed");
    invalid_low_a: assert property (still_invalid_s |=> !valid_r)
        else $error("validity not dropped after invalid window");
    valid_high_a: assert property (lvl_any && val_cnt_r == stpm_pkg::VALID_CYC - 13'h1 |=> valid_r)
        else $error("validity not raised after valid window");
    rx_gate_a: assert property (five_rx && state_nxt == stpm_pkg::ST_OFF |=> !rx_inv_oe_r && rx_wake_oe_r)
        else $error("inverting receivers not disabled in powerdown");
endmodule : stpm_power_manager

// ==== bench/stpm_host_model.sv ====
// Host power-management logic that drives the two control pins
module stpm_host_model (
    input wire logic aclk,
    input wire logic [1:0] mode,
    input wire logic cmd_shut_n,
    input wire logic cmd_dis,
    input wire logic valid_out,
    output logic manual_shutdown_n,
    output logic auto_pd_disable_in
);
    timeunit 1ns;
    timeprecision 1ps;

    // Pins start in the always-on strap, then change just after each edge; one process drives
    initial begin
        manual_shutdown_n = 1'b1;
        auto_pd_disable_in = 1'b1;
        forever begin
            @(posedge aclk);
            case (mode)
                2'h1: begin
                    manual_shutdown_n <= valid_out;
                    auto_pd_disable_in <= valid_out;
                end
                2'h2: begin
                    manual_shutdown_n <= valid_out;
                    auto_pd_disable_in <= 1'b0;
                end
                default: begin
                    manual_shutdown_n <= cmd_shut_n;
                    auto_pd_disable_in <= cmd_dis;
                end
            endcase
        end
    end
endmodule : stpm_host_model

// ==== bench/tb_stpm_power_manager.sv ====
// Self-checking bench for the power manager
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; $display("unexpected at %0t: got %0h expected %0h", $time, g, e); end end
module tb_stpm_power_manager;
    timeunit 1ns;
    timeprecision 1ps;
    // Short counts keep the run brief; the timer and wake windows derive from them
    localparam int INACT = 200;
    localparam int WAKE = 20;
    int n_mismatch = 0, n_compared = 0, cyc = 0, n, m;
    logic aclk = 1'b0, aresetn = 1'b0, shut_cmd = 1'b1, dis_cmd = 1'b1;
    logic [1:0] mode = 2'h0, bresp, rresp, r;
    logic [2:0] tx_in = 3'h0;
    logic [4:0] rx_in = 5'h0, lvl = 5'h1f;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic pump_en, tx_oe, rx_inv_oe, rx_wake_oe, ready_out, valid_out, shut_n, dis;

    // Host side of the control pins
    stpm_host_model host_u (.aclk(aclk), .mode(mode), .cmd_shut_n(shut_cmd), .cmd_dis(dis_cmd),
        .valid_out(valid_out), .manual_shutdown_n(shut_n), .auto_pd_disable_in(dis));

    stpm_power_manager #(.INACT_CYC(32'(INACT)), .WAKE_CYC(32'(WAKE))) dut_u (
        .aclk(aclk), .aresetn(aresetn), .tx_in(tx_in), .rx_in(rx_in), .rx_level_ok(lvl),
        .manual_shutdown_n(shut_n), .auto_pd_disable_in(dis), .pump_en(pump_en),
        .tx_oe(tx_oe), .rx_inv_oe(rx_inv_oe), .rx_wake_oe(rx_wake_oe), .ready_out(ready_out),
        .valid_out(valid_out), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready));

    // 125 MHz clock
    initial begin
        forever #4 aclk = ~aclk;
    end

    // Cycle ceiling; the whole run needs about 13400 cycles
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 40000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic finish_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : finish_test

    // Steady power state with no input edges for a long time
    function automatic logic exp_on(input logic s, input logic f);
        return s & f;
    endfunction : exp_on

    // AXI4-Lite write; each channel released at its own handshake
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
        logic ah, wh, bh;
        @(posedge aclk);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            #1;
            ah = awvalid && awready;
            wh = wvalid && wready;
            bh = bvalid;
            rs = bresp;
            @(posedge aclk);
            if (ah) awvalid <= 1'b0;
            if (wh) wvalid <= 1'b0;
        end while (!bh);
        bready <= 1'b0;
    endtask : axi_wr

    // AXI4-Lite read
    task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
        logic ah, rh;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            #1;
            ah = arvalid && arready;
            rh = rvalid;
            v = rdata;
            rs = rresp;
            @(posedge aclk);
            if (ah) arvalid <= 1'b0;
        end while (!rh);
        rready <= 1'b0;
    endtask : axi_rd

    // Cycles until ready (sel 0) or validity (sel 1) reaches v, capped at lim
    task automatic meas(input int sel, input logic v, input int lim, output int k);
        k = 0;
        do begin
            @(posedge aclk);
            #1;
            k++;
        end while (((sel == 0) ? ready_out : valid_out) !== v && k < lim);
    endtask : meas

    // One random edge on a transmitter or receiver input
    task automatic kick;
        @(posedge aclk);
        if ($urandom % 2) tx_in <= tx_in ^ 3'(1 << ($urandom % 3));
        else rx_in <= rx_in ^ 5'(1 << ($urandom % 5));
    endtask : kick

    // Main sequence
    initial begin
        void'($urandom(45385));
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        meas(0, 1'b1, 100, n);
        `CHK(n >= WAKE && n <= WAKE + 15, 1'b1)
        repeat (3 * INACT) @(posedge aclk);
        `CHK(ready_out, exp_on(1'b1, 1'b1))
        axi_rd(stpm_pkg::CTRL_OFFS, d, r);
        `CHK(d, stpm_pkg::CTRL_RESET)
        axi_rd(stpm_pkg::STATUS_OFFS, d, r);
        `CHK({d[6:5], d[1], r}, {3'h7, stpm_pkg::RESP_OKAY})
        axi_rd(8'h10, d, r);
        `CHK({d, r}, {32'h0, stpm_pkg::RESP_SLVERR})
        axi_wr(8'h10, 32'h0, r);
        `CHK(r, stpm_pkg::RESP_SLVERR)
        // Manual powerdown overrides the disable input
        shut_cmd <= 1'b0;
        repeat (20) @(posedge aclk);
        `CHK({ready_out, tx_oe, pump_en, rx_inv_oe, rx_wake_oe, valid_out}, 6'h03)
        // Disable low, shutdown high: stays off until an edge
        dis_cmd <= 1'b0;
        shut_cmd <= 1'b1;
        repeat (50) @(posedge aclk);
        `CHK(ready_out, 1'b0)
        kick();
        meas(0, 1'b1, 100, n);
        `CHK(n >= WAKE && n <= WAKE + 15, 1'b1)
        meas(0, 1'b0, 2 * INACT, m);
        `CHK(n + m >= INACT && n + m <= INACT + 12, 1'b1)
        repeat (50) @(posedge aclk);
        `CHK(tx_oe, 1'b0)
        // Disable rise wakes, its fall restarts the full timer
        dis_cmd <= 1'b1;
        meas(0, 1'b1, 100, n);
        `CHK(ready_out, 1'b1)
        dis_cmd <= 1'b0;
        meas(0, 1'b0, 2 * INACT, n);
        `CHK(n >= INACT && n <= INACT + 12, 1'b1)
        // Soft wake acts as an edge; clearing the variant keeps receivers on
        axi_wr(stpm_pkg::CTRL_OFFS, 32'h0000_0003, r);
        meas(0, 1'b1, 100, n);
        `CHK(n <= WAKE + 15, 1'b1)
        dis_cmd <= 1'b1;
        shut_cmd <= 1'b0;
        repeat (20) @(posedge aclk);
        `CHK(rx_inv_oe, 1'b0)
        axi_wr(stpm_pkg::CTRL_OFFS, 32'h0, r);
        repeat (5) @(posedge aclk);
        `CHK(rx_inv_oe, 1'b1)
        shut_cmd <= 1'b1;
        meas(0, 1'b1, 100, n);
        // Validity detector in the forced-on mode
        @(posedge aclk);
        lvl <= 5'h00;
        meas(1, 1'b0, 5000, n);
        `CHK(n >= 3751 && n <= 3762, 1'b1)
        `CHK(ready_out, 1'b1)
        @(posedge aclk);
        lvl <= 5'(1 << ($urandom % 5));
        meas(1, 1'b1, 300, n);
        `CHK(n >= 125 && n <= 136, 1'b1)
        // Validity driving both pins emulates plain auto powerdown
        @(posedge aclk);
        mode <= 2'h1;
        lvl <= 5'h00;
        meas(0, 1'b0, 5000, n);
        `CHK(tx_oe, 1'b0)
        @(posedge aclk);
        lvl <= 5'($urandom % 31 + 1);
        meas(0, 1'b1, 300, n);
        `CHK(tx_oe, 1'b1)
        // Hybrid: after cable loss, valid levels alone do not wake
        @(posedge aclk);
        mode <= 2'h2;
        lvl <= 5'h00;
        meas(1, 1'b0, 5000, n);
        `CHK(n >= 3751 && n <= 3762, 1'b1)
        `CHK({pump_en, ready_out}, 2'h0)
        @(posedge aclk);
        lvl <= 5'($urandom % 31 + 1);
        repeat (300) @(posedge aclk);
        `CHK({valid_out, ready_out}, 2'h2)
        kick();
        meas(0, 1'b1, 100, n);
        `CHK(ready_out, 1'b1)
        finish_test();
    end
endmodule : tb_stpm_power_manager
